// ### rtl/boot_loader_defs.svh
// constants for the serial container boot loader
`ifndef BOOT_LOADER_DEFS_SVH
`define BOOT_LOADER_DEFS_SVH
`define CLK_FREQ_HZ        100000000
`define SYS_FREQ_HZ        1000000
`define SCK_HALF_CYC       50
`define BOOST_FREQ_HZ      250000
`define BOOST_HALF_CYC     200
`define BOOST_WAIT_US      500
`define BOOST_WAIT_CYC     ((`BOOST_WAIT_US * (`CLK_FREQ_HZ / 1000000)))
`define BLINK_PERIOD_MS    1000
`define BLINK_PERIOD_CYC   ((`BLINK_PERIOD_MS * (`CLK_FREQ_HZ / 1000)))
`define BLINK_COUNT        3
`define FORMAT_ADDR        24'h000000
`define FIRST_CONT_ADDR    24'h000002
`define OVL_SPI_LOW_RST    16'h0002
`define OVL_SPI_HIGH_RST   16'h0000
`define OVL_OFFSET_RST     16'h0000
`define STATUS_RST         16'h0000
`define READ_CMD           8'h03
`define FORMAT_24BIT       16'h0024
`define ID_FAIL            32'hffffffff
`endif

// ### rtl/boot_loader_pkg.sv
// types shared by the boot loader files
package boot_loader_pkg;
  typedef enum logic [10:0] {
    ST_IDLE    = 11'h001,
    ST_BOOST   = 11'h002,
    ST_FMT     = 11'h004,
    ST_HDR     = 11'h008,
    ST_PAY     = 11'h010,
    ST_PAD     = 11'h020,
    ST_TRL     = 11'h040,
    ST_START   = 11'h080,
    ST_BLINK   = 11'h100,
    ST_STOP    = 11'h200,
    ST_DONE    = 11'h400
  } load_state_e;
endpackage

// ### rtl/byte_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  logic             push;
  logic             pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = (wptr - rptr) != (AW+1)'(DEPTH);
  assign out_valid_o = wptr != rptr;
  assign out_data_o  = mem[rptr[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
    end
  end
endmodule

// ### rtl/spi_container_boot_loader.sv
// serial memory container boot loader with checksum and error signature
// Behaviour
// - header is three 16-bit words: length, load address, start address
// - length word counts payload bytes copied into on-chip memory
// - odd length is followed by one pad byte skipped before trailer
// - payload length up to 65536 bytes is supported
// - payload goes to header load address unless alternate address nonzero
// - trailer holds two checksum copies over header and payload words
// - checksum is xor of 16-bit words, starting from zero
// - missing memory or load error blinks the indicator
// - error pattern pulses indicator three times at about one hertz
// - after error pattern never start code, enter deep stop state
// - serial port is chip select, mosi, sck out and miso in
// - idle holds chip select high, mosi and sck low
// - loader runs from the 100 MHz clock; serial clock at the 1 MHz system rate
// - overlay low address resets to 0x0002, other words to zero
// - identifier given, all ones when integrity check fails
// - control passes to loaded code only after checksum matches
// - format word at addresses 0 and 1 selects 16 or 24 bit address
// - first container is fetched from serial address two
// - 250 kHz booster clock then about 500 us wait before reading
`timescale 1ns/100ps
`include "boot_loader_defs.svh"
module spi_container_boot_loader #(
  parameter int BOOST_WAIT  = `BOOST_WAIT_CYC,
  parameter int BLINK_CYC   = `BLINK_PERIOD_CYC,
  parameter int FIFO_DEPTH  = 32,
  parameter logic [31:0] LOADER_ID = 32'h5a3c_0101 // arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        start_i,
  input  wire logic        ram_lock_bit_one_i,
  input  wire logic        ram_lock_bit_zero_i,
  input  wire logic [15:0] alt_load_addr_i,
  input  wire logic        integrity_ok_i,
  input  wire logic        spi_miso_i,
  input  wire logic        mem_ready_i,
  output logic             spi_cs_n_o,
  output logic             spi_mosi_o,
  output logic             spi_sck_o,
  output logic             booster_clock_pin_o,
  output logic             mem_we_o,
  output logic      [15:0] mem_addr_o,
  output logic      [7:0]  mem_data_o,
  output logic             start_valid_o,
  output logic      [15:0] start_addr_o,
  output logic             deep_stop_state_o,
  output logic             load_error_o,
  output logic      [15:0] loader_status_o,
  output logic      [15:0] current_overlay_serial_addr_low_o,
  output logic      [15:0] current_overlay_serial_addr_high_o,
  output logic      [15:0] current_overlay_offset_o,
  output logic      [31:0] loader_id_o
);
  boot_loader_pkg::load_state_e state;
  logic        miso_s1, miso_s2;
  logic [7:0]  div;
  logic        sck_int;
  logic        shifting;
  logic [5:0]  bit_cnt;
  logic [31:0] tx_sh;
  logic [7:0]  rx_sh;
  logic        byte_done;
  logic [31:0] wait_cnt;
  logic [7:0]  boost_div;
  logic        addr24;
  logic [3:0]  idx;
  logic [15:0] word;
  logic        hi_byte;
  logic [15:0] len;
  logic [15:0] load_addr;
  logic [15:0] start_addr;
  logic [16:0] remain;
  logic [15:0] csum;
  logic        csum_bad;
  logic [1:0]  blinks;
  logic        fifo_in_ready;
  logic [7:0]  fifo_data;
  logic        fifo_valid;
  logic        fifo_ready;
  logic        unlocked;
  logic        pay_byte;

  // ram lock bits must both be clear for the loader to act
  assign unlocked  = !ram_lock_bit_one_i && !ram_lock_bit_zero_i;
  assign pay_byte  = byte_done && state == boot_loader_pkg::ST_PAY;
  // payload bytes stall the serial clock while the fifo is full
  assign fifo_ready = mem_ready_i;

  // miso passes two flops before use
  always_ff @(posedge clk_i) begin
    miso_s1 <= spi_miso_i;
    miso_s2 <= miso_s1;
  end

  // serial engine: mode zero, msb first; sck at the 1 MHz system rate
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      div       <= '0;
      sck_int   <= 1'b0;
      bit_cnt   <= '0;
      rx_sh     <= '0;
      byte_done <= 1'b0;
      spi_mosi_o <= 1'b0;
    end else begin
      byte_done <= 1'b0;
      if (!shifting) begin
        div        <= '0;
        bit_cnt    <= '0;
        sck_int    <= 1'b0;
        spi_mosi_o <= 1'b0;
      end else if (div == 8'(`SCK_HALF_CYC - 1)) begin
        div <= '0;
        if (!sck_int) begin
          if (fifo_in_ready) begin
            sck_int <= 1'b1;
            rx_sh   <= {rx_sh[6:0], miso_s2};
          end
        end else begin
          sck_int    <= 1'b0;
          bit_cnt    <= bit_cnt + 6'd1;
          // the register shifts on this edge, so present the next bit now
          spi_mosi_o <= tx_sh[30];
          if (bit_cnt[2:0] == 3'd7) begin
            byte_done <= 1'b1;
          end
        end
      end else begin
        div <= div + 8'd1;
        if (div == 8'd0 && !sck_int && bit_cnt == 6'd0) begin
          spi_mosi_o <= tx_sh[31];
        end
      end
    end
  end
  assign spi_sck_o = sck_int;

  // command and address shift register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tx_sh <= '0;
    end else if (state == boot_loader_pkg::ST_BOOST
                 && wait_cnt == 32'(BOOST_WAIT)) begin
      tx_sh <= {`READ_CMD, `FORMAT_ADDR};
    end else if (state == boot_loader_pkg::ST_FMT && idx == 4'd6) begin
      // narrow parts take a two byte address; the last byte is filler
      tx_sh <= {`READ_CMD, 16'h0002, 8'h00};
    end else if (shifting && sck_int
                 && div == 8'(`SCK_HALF_CYC - 1)) begin
      tx_sh <= {tx_sh[30:0], 1'b0};
    end
  end

  // 250 kHz booster clock, wait then read
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      boost_div           <= '0;
      booster_clock_pin_o <= 1'b0;
    end else if (state == boot_loader_pkg::ST_IDLE
                 || state == boot_loader_pkg::ST_STOP
                 || state == boot_loader_pkg::ST_DONE
                 || (state == boot_loader_pkg::ST_BLINK && blinks == 2'd3)) begin
      boost_div           <= '0;
      booster_clock_pin_o <= 1'b0;
    end else if (state == boot_loader_pkg::ST_BLINK) begin
      booster_clock_pin_o <= wait_cnt < 32'(BLINK_CYC / 2);
    end else if (boost_div == 8'(`BOOST_HALF_CYC - 1)) begin
      boost_div           <= '0;
      booster_clock_pin_o <= !booster_clock_pin_o;
    end else begin
      boost_div <= boost_div + 8'd1;
    end
  end

  // main sequence
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state      <= boot_loader_pkg::ST_IDLE;
      spi_cs_n_o <= 1'b1;
      shifting   <= 1'b0;
      wait_cnt   <= '0;
      addr24     <= 1'b0;
      idx        <= '0;
      word       <= '0;
      hi_byte    <= 1'b1;
      len        <= '0;
      load_addr  <= '0;
      start_addr <= '0;
      remain     <= '0;
      csum       <= '0;
      csum_bad   <= 1'b0;
      blinks     <= '0;
    end else begin
      case (state)
        boot_loader_pkg::ST_IDLE: begin
          spi_cs_n_o <= 1'b1;
          if (start_i && unlocked) begin
            wait_cnt <= '0;
            state    <= boot_loader_pkg::ST_BOOST;
          end
        end
        boot_loader_pkg::ST_BOOST: begin
          wait_cnt <= wait_cnt + 32'd1;
          if (wait_cnt == 32'(BOOST_WAIT)) begin
            spi_cs_n_o <= 1'b0;
            shifting   <= 1'b1;
            idx        <= '0;
            state      <= boot_loader_pkg::ST_FMT;
          end
        end
        boot_loader_pkg::ST_FMT: begin
          if (idx == 4'd6) begin
            // one cycle deselected ends the first read before the reissue
            spi_cs_n_o <= 1'b0;
            shifting   <= 1'b1;
            idx        <= 4'd7;
          end else if (byte_done) begin
            // bytes 0 to 3 carry the command frame, 4 and 5 the format word
            idx  <= idx + 4'd1;
            word <= {word[7:0], rx_sh};
            if (idx == 4'd5) begin
              // erased or absent memory reads all ones
              if ({word[7:0], rx_sh} == 16'hffff) begin
                wait_cnt <= '0;
                state    <= boot_loader_pkg::ST_BLINK;
              end else if ({word[7:0], rx_sh} == `FORMAT_24BIT) begin
                addr24  <= 1'b1;
                idx     <= '0;
                hi_byte <= 1'b1;
                csum    <= '0;
                state   <= boot_loader_pkg::ST_HDR;
              end else begin
                // narrow part: stop and read again at the first container
                shifting   <= 1'b0;
                spi_cs_n_o <= 1'b1;
              end
            end else if (idx == 4'd9) begin
              // command and two address bytes of the reissued read skipped
              idx     <= '0;
              hi_byte <= 1'b1;
              csum    <= '0;
              state   <= boot_loader_pkg::ST_HDR;
            end
          end
        end
        boot_loader_pkg::ST_HDR: begin
          if (byte_done) begin
            hi_byte <= !hi_byte;
            word    <= {word[7:0], rx_sh};
            if (!hi_byte) begin
              csum <= csum ^ {word[7:0], rx_sh};
              idx  <= idx + 4'd1;
              case (idx)
                4'd0: begin
                  len    <= {word[7:0], rx_sh};
                  remain <= {1'b0, word[7:0], rx_sh};
                end
                4'd1: load_addr  <= alt_load_addr_i != 16'h0000 ?
                                    alt_load_addr_i :
                                    {word[7:0], rx_sh};
                default: begin
                  start_addr <= {word[7:0], rx_sh};
                  hi_byte    <= 1'b1;
                  idx        <= '0;
                  // zero length stands for the full 65536 byte block
                  if (len == 16'h0000) begin
                    remain <= 17'h10000;
                  end
                  state <= boot_loader_pkg::ST_PAY;
                end
              endcase
            end
          end
        end
        boot_loader_pkg::ST_PAY: begin
          if (byte_done) begin
            hi_byte <= !hi_byte;
            word    <= {word[7:0], rx_sh};
            remain  <= remain - 17'd1;
            if (!hi_byte) begin
              csum <= csum ^ {word[7:0], rx_sh};
            end
            if (remain == 17'd1) begin
              state <= len[0] ? boot_loader_pkg::ST_PAD
                              : boot_loader_pkg::ST_TRL;
            end
          end
        end
        boot_loader_pkg::ST_PAD: begin
          if (byte_done) begin
            csum    <= csum ^ {word[7:0], rx_sh};
            hi_byte <= 1'b1;
            state   <= boot_loader_pkg::ST_TRL;
          end
        end
        boot_loader_pkg::ST_TRL: begin
          if (byte_done) begin
            hi_byte <= !hi_byte;
            word    <= {word[7:0], rx_sh};
            if (!hi_byte) begin
              idx <= idx + 4'd1;
              if ({word[7:0], rx_sh} != csum) begin
                csum_bad <= 1'b1;
              end
              if (idx == 4'd1) begin
                shifting   <= 1'b0;
                spi_cs_n_o <= 1'b1;
                state      <= boot_loader_pkg::ST_START;
              end
            end
          end
        end
        boot_loader_pkg::ST_START: begin
          wait_cnt <= '0;
          blinks   <= '0;
          if (csum_bad) begin
            state <= boot_loader_pkg::ST_BLINK;
          end else if (!fifo_valid) begin
            state <= boot_loader_pkg::ST_DONE;
          end
        end
        boot_loader_pkg::ST_BLINK: begin
          shifting   <= 1'b0;
          spi_cs_n_o <= 1'b1;
          if (wait_cnt == 32'(BLINK_CYC - 1)) begin
            wait_cnt <= '0;
            blinks   <= blinks + 2'd1;
            if (blinks == 2'(`BLINK_COUNT - 1)) begin
              state <= boot_loader_pkg::ST_STOP;
            end
          end else begin
            wait_cnt <= wait_cnt + 32'd1;
          end
        end
        boot_loader_pkg::ST_STOP: begin
          state <= boot_loader_pkg::ST_STOP;
        end
        boot_loader_pkg::ST_DONE: begin
          state <= boot_loader_pkg::ST_DONE;
        end
        default: state <= boot_loader_pkg::ST_IDLE;
      endcase
    end
  end

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) pay_fifo (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .in_data_i   (rx_sh),
    .in_valid_i  (pay_byte),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_ready)
  );

  // memory write port; address advances from the load address
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mem_we_o   <= 1'b0;
      mem_addr_o <= '0;
      mem_data_o <= '0;
    end else begin
      mem_we_o <= fifo_valid && fifo_ready;
      if (state == boot_loader_pkg::ST_HDR) begin
        mem_addr_o <= load_addr - 16'd1;
      end else if (fifo_valid && fifo_ready) begin
        mem_addr_o <= mem_addr_o + 16'd1;
        mem_data_o <= fifo_data;
      end
    end
  end

  // outputs: start only on a good checksum, stop after error
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      start_valid_o     <= 1'b0;
      start_addr_o      <= '0;
      deep_stop_state_o <= 1'b0;
      load_error_o      <= 1'b0;
      loader_status_o   <= `STATUS_RST;
      current_overlay_serial_addr_low_o  <= `OVL_SPI_LOW_RST;
      current_overlay_serial_addr_high_o <= `OVL_SPI_HIGH_RST;
      current_overlay_offset_o           <= `OVL_OFFSET_RST;
      loader_id_o       <= '0;
    end else begin
      start_valid_o <= state == boot_loader_pkg::ST_DONE && !csum_bad;
      start_addr_o  <= start_addr;
      deep_stop_state_o <= state == boot_loader_pkg::ST_STOP;
      load_error_o  <= state == boot_loader_pkg::ST_BLINK
                       || state == boot_loader_pkg::ST_STOP;
      loader_status_o <= {14'h0000, csum_bad, addr24};
      loader_id_o   <= integrity_ok_i ? LOADER_ID : `ID_FAIL;
    end
  end

  start_after_check_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    start_valid_o |-> !csum_bad && !load_error_o)
    else $error("start raised with bad checksum");
  stop_no_start_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    deep_stop_state_o |-> !start_valid_o)
    else $error("start during deep stop");
  idle_pins_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    spi_cs_n_o |-> ##1 !spi_sck_o)
    else $error("clock active while deselected");
  bad_sum_blink_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == boot_loader_pkg::ST_START && csum_bad
    |=> state == boot_loader_pkg::ST_BLINK)
    else $error("checksum error not signalled");
  overlay_reset_a: assert property (@(posedge clk_i)
    $rose(rstn_i) |-> current_overlay_serial_addr_low_o == 16'h0002)
    else $error("overlay low address reset wrong");
  id_fail_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !integrity_ok_i |=> loader_id_o == 32'hffffffff)
    else $error("identifier not all ones on failure");
  pad_skip_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == boot_loader_pkg::ST_PAY && byte_done && remain == 17'd1
    && len[0] |=> state == boot_loader_pkg::ST_PAD)
    else $error("pad byte not skipped");
  locked_idle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == boot_loader_pkg::ST_IDLE && !unlocked
    |=> state == boot_loader_pkg::ST_IDLE)
    else $error("started while locked");
endmodule

// ### sim/spi_mem_model.sv
// serial memory model for the boot loader bench, read command only
`timescale 1ns/100ps
module spi_mem_model (
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic mosi_i,
  input  wire logic present_i,
  input  wire logic wide_i,
  output logic      miso_o
);
  logic [7:0]  mem [0:255];
  logic [31:0] hdr;
  logic        drv;
  int          cnt;
  int          k;
  int          nb;
  logic [23:0] a;
  initial begin
    nb = 32;
    a = 24'h0;
    for (int i = 0; i < 256; i++) mem[i] = 8'hee;
    hdr = 32'h0;
    drv = 1'b0;
    cnt = 0;
  end
  // absent part: the line floats up to its pull-up
  assign miso_o = present_i ? drv : 1'b1;
  // a released output shows the inverse of its last bit, never a held value
  always @(cs_n_i) begin
    cnt = 0;
    nb = wide_i ? 32 : 24;
    drv = ~drv;
  end
  // command and 16- or 24-bit address shift in msb first on sck rise
  always @(posedge sck_i) begin
    if (!cs_n_i) begin
      if (cnt < nb) hdr = {hdr[30:0], mosi_i};
      cnt++;
    end
  end
  // data changes on sck fall, so it holds well past the sampling rise
  always @(negedge sck_i) begin
    a = (nb == 32) ? hdr[23:0] : {8'h00, hdr[15:0]};
    if (!cs_n_i && cnt >= nb && hdr[nb-1 -: 8] == 8'h03) begin
      k = cnt - nb;
      drv = mem[8'(a + 24'(k / 8))][7 - k % 8];
    end
  end
endmodule

// ### sim/spi_container_boot_loader_test.sv
// self-checking bench for the serial container boot loader
`timescale 1ns/100ps
module spi_container_boot_loader_test;
  localparam int          BW = 500;
  localparam int          BC = 500;
  localparam logic [31:0] ID = 32'h0bad_cafe; // arbitrary value
  logic        clk_i, rstn_i, start_i, lk1, lk0, iok, rdy, present, wide;
  logic        cs_n, mosi, sck, boost, we, sv, stop, lerr, miso, seen;
  logic [15:0] alt, maddr, saddr, stat, ovl_l, ovl_h, ovl_o, wbase;
  logic [7:0]  mdata;
  logic [31:0] lid, cmd;
  int          errors, checked, frames, bits, n_wr, bad_wr;
  time         t1, t2, last_sck;

  spi_container_boot_loader #(.BOOST_WAIT(BW), .BLINK_CYC(BC),
    .LOADER_ID(ID)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i),
    .ram_lock_bit_one_i(lk1), .ram_lock_bit_zero_i(lk0),
    .alt_load_addr_i(alt), .integrity_ok_i(iok), .spi_miso_i(miso),
    .mem_ready_i(rdy), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi),
    .spi_sck_o(sck), .booster_clock_pin_o(boost), .mem_we_o(we),
    .mem_addr_o(maddr), .mem_data_o(mdata), .start_valid_o(sv),
    .start_addr_o(saddr), .deep_stop_state_o(stop), .load_error_o(lerr),
    .loader_status_o(stat), .current_overlay_serial_addr_low_o(ovl_l),
    .current_overlay_serial_addr_high_o(ovl_h),
    .current_overlay_offset_o(ovl_o), .loader_id_o(lid));

  spi_mem_model mdl_u (.cs_n_i(cs_n), .sck_i(sck), .mosi_i(mosi),
    .present_i(present), .wide_i(wide), .miso_o(miso));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [7:0] pay(input int i);
    return 8'(i * 5 + 3);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wait_for(ref logic s, input logic v, input int lim,
                          output int c);
    c = 0;
    while (s !== v && c < lim) begin
      tick(1);
      c++;
    end
  endtask

  task automatic do_reset();
    rstn_i = 1'b0;
    start_i = 1'b0;
    tick(20);
    rstn_i = 1'b1;
    frames = 0;
    bits = 0;
    n_wr = 0;
    bad_wr = 0;
    seen = 1'b0;
    tick(1);
  endtask

  task automatic go();
    start_i = 1'b1;
    tick(1);
    start_i = 1'b0;
  endtask

  task automatic put(input int a, input logic [15:0] w);
    mdl_u.mem[a] = w[15:8];
    mdl_u.mem[a + 1] = w[7:0];
  endtask

  task automatic build(input int n, input logic [15:0] ld, st,
                       input bit bad);
    logic [15:0] x;
    logic [15:0] w;
    int          a;
    put(0, 16'h0024);
    put(2, n[15:0]);
    put(4, ld);
    put(6, st);
    x = n[15:0] ^ ld ^ st;
    for (int i = 0; i < n + n % 2; i += 2) begin
      w = {pay(i), (i + 1 < n) ? pay(i + 1) : 8'h00};
      put(8 + i, w);
      x ^= w;
    end
    a = 8 + n + n % 2;
    put(a, x);
    put(a + 2, bad ? ~x : x);
  endtask

  // three slow pulses, then a stop that holds with the pin quiet
  task automatic blinks();
    int   n, c;
    logic p;
    n = 0;
    c = 0;
    p = boost;
    while (stop !== 1'b1 && c < 8 * BC) begin
      tick(1);
      c++;
      // falls are counted: the first pulse may already be high on entry
      if (boost === 1'b0 && p === 1'b1) n++;
      p = boost;
    end
    chk(n, 3);
    chk(c > 2 * BC, 1);
    chk({stop, sv}, 2'b10);
    tick(2 * BC);
    chk({boost, sv, stop}, 3'b001);
  endtask

  always @(posedge clk_i) begin
    if (we === 1'b1) begin
      if ({maddr, mdata} !== {wbase + 16'(n_wr), pay(n_wr)}) bad_wr++;
      n_wr++;
    end
  end
  always @(negedge cs_n) begin
    frames++;
    bits = 0;
  end
  always @(posedge boost) seen = 1'b1;
  always @(posedge sck) begin
    last_sck = $time;
    if (bits < 32) cmd = {cmd[30:0], mosi};
    if (bits == 0) t1 = $time;
    if (bits == 1) t2 = $time;
    bits++;
  end
  always @(negedge clk_i) begin
    if (rstn_i && cs_n === 1'b1 && {sck, mosi} !== 2'b00)
      chk({sck, mosi}, 2'b00);
  end

  task automatic t_reset();
    do_reset();
    tick(2);
    chk({cs_n, mosi, sck, boost}, 4'b1000);
    chk(ovl_l, 16'h0002);
    chk(ovl_h, 16'h0000);
    chk({ovl_o, stat}, 32'h0);
    chk(lid, ID);
    iok = 1'b0;
    tick(2);
    chk(lid, 32'hffff_ffff);
    iok = 1'b1;
    lk1 = 1'b1;
    lk0 = 1'b1;
    go();
    tick(BW + 50);
    chk({cs_n, boost, seen}, 3'b100);
    lk1 = 1'b0;
    lk0 = 1'b0;
    $display("test reset_and_lock done");
  endtask

  task automatic t_load();
    int c;
    do_reset();
    build(33, 16'h0100, 16'h0104, 1'b0);
    wbase = 16'h0100;
    alt = 16'h0000;
    rdy = 1'b0;
    go();
    wait_for(cs_n, 1'b0, BW + 60, c);
    chk(seen && c > BW - 10, 1);
    // sink held off: the buffer fills and the serial clock must stop
    tick(37000);
    chk($time - last_sck > 10000, 1);
    rdy = 1'b1;
    wait_for(sv, 1'b1, 40000, c);
    chk({sv, lerr, stop}, 3'b100);
    chk(saddr, 16'h0104);
    chk(n_wr, 33);
    chk(bad_wr, 0);
    chk(cmd, 32'h0300_0000);
    chk(frames, 1);
    chk(32'(t2 - t1), 1000);
    chk(stat, 16'h0001);
    tick(4);
    chk({cs_n, sck}, 2'b10);
    $display("test good_load done");
  endtask

  task automatic t_bad();
    int c;
    do_reset();
    build(3, 16'h0100, 16'h0100, 1'b1);
    alt = 16'h0300;
    wbase = 16'h0300;
    go();
    wait_for(lerr, 1'b1, 20000, c);
    chk({lerr, stat[1]}, 2'b11);
    chk(n_wr, 3);
    chk(bad_wr, 0);
    blinks();
    $display("test bad_checksum done");
  endtask

  task automatic t_absent();
    int c;
    do_reset();
    present = 1'b0;
    alt = 16'h0000;
    go();
    wait_for(lerr, 1'b1, 10000, c);
    chk(lerr, 1);
    blinks();
    chk(n_wr, 0);
    present = 1'b1;
    $display("test no_memory done");
  endtask

  task automatic t_narrow();
    int c;
    do_reset();
    wide = 1'b0;
    alt = 16'h0000;
    build(3, 16'h0040, 16'h0042, 1'b0);
    put(0, 16'h0016);
    wbase = 16'h0040;
    go();
    wait_for(sv, 1'b1, 30000, c);
    chk({sv, lerr, stop}, 3'b100);
    chk(stat, 16'h0000);
    chk(saddr, 16'h0042);
    chk(frames, 2);
    chk(cmd, 32'h0300_0200);
    chk(n_wr, 3);
    chk(bad_wr, 0);
    wide = 1'b1;
    $display("test narrow_address done");
  endtask

  initial begin
    #950000;
    errors++;
    close_out();
  end

  initial begin
    errors = 0;
    checked = 0;
    rstn_i = 1'b0;
    start_i = 1'b0;
    lk1 = 1'b0;
    lk0 = 1'b0;
    iok = 1'b1;
    rdy = 1'b1;
    present = 1'b1;
    wide = 1'b1;
    alt = 16'h0000;
    wbase = 16'h0000;
    cmd = 32'h0;
    t_reset();
    t_load();
    t_bad();
    t_absent();
    t_narrow();
    close_out();
  end
endmodule
